// ==== verilog/qdma_channel_event_logic.sv ====
`include "qdma_event_regs.svh"

module qdma_channel_event_logic
   import qdma_event_pkg::*;
#(
   parameter int CHANNELS = 8,
   parameter int ENTRY_W = 7,
   parameter int ADDR_W = 12
) (
   input wire logic sys_clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // parameter ram write and link update observers
   input wire logic ram_write,
   input wire logic [ENTRY_W-1:0] ram_write_entry,
   input wire logic [2:0] ram_write_word,
   input wire logic link_update,
   input wire logic [ENTRY_W-1:0] link_entry,
   // arbitration against normal channel events
   input wire logic normal_pending,
   // transfer request submission
   output logic tr_request,
   output logic [2:0] tr_channel,
   input wire logic tr_accept,
   // queue leave report from the queue logic
   input wire logic dequeue,
   input wire logic [2:0] dequeue_channel,
   input wire logic dequeue_null,
   output logic irq
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (CHANNELS < 1 || CHANNELS > 8) begin : g_bad_channels
      $error("CHANNELS must lie between 1 and 8");
   end
   if (ENTRY_W < 1 || ENTRY_W > 27) begin : g_bad_entry
      $error("ENTRY_W must lie between 1 and 27");
   end
   if (ADDR_W < 7 || ADDR_W > 12) begin : g_bad_addr
      $error("ADDR_W must lie between 7 and 12");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [CHANNELS-1:0] event_latch;
   logic [CHANNELS-1:0] channel_event_enable;
   logic [CHANNELS-1:0] channel_in_queue_flags;
   logic [CHANNELS-1:0] missed_event_flags;
   logic [ENTRY_W-1:0] map_entry [CHANNELS];
   logic [2:0] map_word [CHANNELS];
   logic quick_first;
   logic [15:0] irq_status;
   logic [15:0] irq_mask;
   submit_state_t submit_state;

   logic [11:0] addr;
   logic setup_phase;
   logic wr_done;
   logic mapped;
   logic [CHANNELS-1:0] wbits;
   logic [CHANNELS-1:0] trig_hit;
   logic [CHANNELS-1:0] link_hit;
   logic [CHANNELS-1:0] new_event;
   logic [CHANNELS-1:0] hw_clear;
   logic [CHANNELS-1:0] sw_clear;
   logic [CHANNELS-1:0] dq_clear;
   logic [CHANNELS-1:0] dq_null;
   logic [CHANNELS-1:0] candidates;
   logic pick_found;
   logic [2:0] pick_index;

   // zero-extend a channel vector into a bus word
   function automatic apb_word_t widen(input logic [CHANNELS-1:0] v);
      apb_word_t w;
      w = 32'h0000_0000;
      w[CHANNELS-1:0] = v;
      return w;
   endfunction : widen

   // one-hot mask of a channel number, empty when out of range
   function automatic logic [CHANNELS-1:0] onehot(input logic [2:0] ch);
      logic [CHANNELS-1:0] r;
      r = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (ch == 3'(i)) begin
            r[i] = 1'b1;
         end
      end
      return r;
   endfunction : onehot

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   // writes act at the edge that samples pready high in the access phase
   always_comb begin
      addr = 12'(paddr);
      setup_phase = psel & ~penable;
      wr_done = psel & penable & pready & pwrite & ~pslverr;
      wbits = pwdata[CHANNELS-1:0];
      mapped = (addr <= `OFS_IRQ_MASK && addr[1:0] == 2'b00)
         || (addr >= `OFS_MAPPING_BASE && addr < `OFS_MAPPING_BASE + 12'(4 * CHANNELS) && addr[1:0] == 2'b00);
   end

   // ----------------------------------------------------------------
   // event detection
   // ----------------------------------------------------------------
   // a trigger needs both entry and word to match; link updates match on the entry alone
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         trig_hit[i] = ram_write && ram_write_entry == map_entry[i] && ram_write_word == map_word[i];
         link_hit[i] = link_update && link_entry == map_entry[i];
      end
      new_event = (trig_hit | link_hit) & channel_event_enable;
      hw_clear = (submit_state == SUBMIT_OFFER && tr_accept) ? onehot(tr_channel) : '0;
      sw_clear = (wr_done && addr == `OFS_IN_QUEUE_CLEAR) ? wbits : '0;
      dq_clear = (dequeue && !dequeue_null) ? onehot(dequeue_channel) : '0;
      dq_null = (dequeue && dequeue_null) ? onehot(dequeue_channel) : '0;
      candidates = event_latch & ~channel_in_queue_flags & ~sw_clear;
   end

   // ----------------------------------------------------------------
   // event latch and missed events
   // ----------------------------------------------------------------
   // set is applied last so that it beats both hardware and software clears
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         event_latch <= `CHANNEL_RESET;
      end else begin
         event_latch <= (event_latch & ~hw_clear & ~sw_clear) | new_event;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         missed_event_flags <= `CHANNEL_RESET;
      end else begin
         missed_event_flags <= (missed_event_flags
            & ~((wr_done && addr == `OFS_MISSED_CLEAR) ? wbits : '0))
            | (new_event & event_latch);
      end
   end

   // ----------------------------------------------------------------
   // channel enables
   // ----------------------------------------------------------------
   // the enable word itself has no write path; only set and clear words change it
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         channel_event_enable <= `CHANNEL_RESET;
      end else if (wr_done && addr == `OFS_ENABLE_CLEAR) begin
         channel_event_enable <= channel_event_enable & ~wbits;
      end else if (wr_done && addr == `OFS_ENABLE_SET) begin
         channel_event_enable <= channel_event_enable | wbits;
      end
   end

   // ----------------------------------------------------------------
   // in-queue flags
   // ----------------------------------------------------------------
   // a null request leaves its flag set, so software has to release the channel
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         channel_in_queue_flags <= `CHANNEL_RESET;
      end else begin
         channel_in_queue_flags <= (channel_in_queue_flags & ~dq_clear & ~sw_clear) | hw_clear;
      end
   end

   // ----------------------------------------------------------------
   // submission
   // ----------------------------------------------------------------
   channel_picker #(
      .CHANNELS(CHANNELS)
   ) u_picker (
      .candidates(candidates),
      .found(pick_found),
      .index(pick_index)
   );

   // the offered channel is frozen until taken; a software clear withdraws the offer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         submit_state <= SUBMIT_IDLE;
         tr_request <= 1'b0;
         tr_channel <= 3'h0;
      end else begin
         unique case (submit_state)
            SUBMIT_IDLE: begin
               if (pick_found && (quick_first || !normal_pending)) begin
                  submit_state <= SUBMIT_OFFER;
                  tr_request <= 1'b1;
                  tr_channel <= pick_index;
               end
            end
            SUBMIT_OFFER: begin
               if (tr_accept || (sw_clear & onehot(tr_channel)) != '0) begin
                  submit_state <= SUBMIT_IDLE;
                  tr_request <= 1'b0;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         for (int i = 0; i < CHANNELS; i++) begin
            map_entry[i] <= '0;
            map_word[i] <= 3'h0;
         end
      end else if (wr_done && addr >= `OFS_MAPPING_BASE) begin
         for (int i = 0; i < CHANNELS; i++) begin
            if (addr == `OFS_MAPPING_BASE + 12'(4 * i)) begin
               map_entry[i] <= pwdata[`MAP_ENTRY_LSB +: ENTRY_W];
               map_word[i] <= pwdata[`MAP_WORD_LSB +: `MAP_WORD_W];
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         quick_first <= `ARB_RESET;
         irq_mask <= `IRQ_RESET;
      end else if (wr_done && addr == `OFS_ARB_CTRL) begin
         quick_first <= pwdata[`ARB_QUICK_FIRST_BIT];
      end else if (wr_done && addr == `OFS_IRQ_MASK) begin
         irq_mask <= pwdata[15:0];
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // missed events in the low byte, null dequeues in the high byte; set beats write-one clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irq_status <= `IRQ_RESET;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~((wr_done && addr == `OFS_IRQ_STATUS) ? pwdata[15:0] : 16'h0000))
            | 16'(new_event & event_latch) | (16'(dq_null) << `IRQ_NULL_LSB);
         irq <= |(irq_status & irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // bus answer
   // ----------------------------------------------------------------
   // one access cycle: pready rises for the access phase that follows each setup
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         prdata <= 32'h0000_0000; // write-only words and reserved bits read zero
         if (setup_phase && !pwrite) begin
            if (addr == `OFS_EVENT_LATCH) begin
               prdata <= widen(event_latch);
            end else if (addr == `OFS_EVENT_ENABLE) begin
               prdata <= widen(channel_event_enable);
            end else if (addr == `OFS_IN_QUEUE) begin
               prdata <= widen(channel_in_queue_flags);
            end else if (addr == `OFS_MISSED) begin
               prdata <= widen(missed_event_flags);
            end else if (addr == `OFS_ARB_CTRL) begin
               prdata <= {31'h0000_0000, quick_first};
            end else if (addr == `OFS_IRQ_STATUS) begin
               prdata <= {16'h0000, irq_status};
            end else if (addr == `OFS_IRQ_MASK) begin
               prdata <= {16'h0000, irq_mask};
            end else begin
               for (int i = 0; i < CHANNELS; i++) begin
                  if (addr == `OFS_MAPPING_BASE + 12'(4 * i)) begin
                     prdata[`MAP_ENTRY_LSB +: ENTRY_W] <= map_entry[i];
                     prdata[`MAP_WORD_LSB +: `MAP_WORD_W] <= map_word[i];
                  end
               end
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_write_to(logic [11:0] where);
      psel && penable && pready && pwrite && !pslverr && addr == where;
   endsequence

   a_latch_needs_enable: assert property (
      ##1 (event_latch & ~$past(event_latch) & ~$past(channel_event_enable)) == '0)
      else $error("latch bit rose on a disabled channel");

   a_trigger_sets_latch: assert property (
      (trig_hit & channel_event_enable) != '0 |=> (event_latch & $past(trig_hit & channel_event_enable)) != '0)
      else $error("trigger write did not set the latch");

   a_set_beats_clear: assert property (
      (new_event & (hw_clear | sw_clear)) != '0 |=> (event_latch & $past(new_event)) == $past(new_event))
      else $error("clear won over a new event");

   a_missed_on_repeat: assert property (
      (new_event & event_latch) != '0
      |=> (missed_event_flags & $past(new_event & event_latch)) == $past(new_event & event_latch))
      else $error("repeated event not recorded as missed");

   a_clear_only_after: assert property (
      ##1 ($past(event_latch) & ~event_latch & ~$past(hw_clear | sw_clear)) == '0)
      else $error("latch bit dropped without submission or clear");

   a_enable_no_direct: assert property (
      s_write_to(`OFS_EVENT_ENABLE) |=> $stable(channel_event_enable))
      else $error("direct write changed the enable word");

   a_enable_clear_set: assert property (
      s_write_to(`OFS_ENABLE_CLEAR) |=> (channel_event_enable & $past(wbits)) == '0)
      else $error("enable clear write left a bit set");

   a_enable_set_bits: assert property (
      s_write_to(`OFS_ENABLE_SET) |=> (channel_event_enable & $past(wbits)) == $past(wbits))
      else $error("enable set write left a bit clear");

   a_queue_on_accept: assert property (
      tr_request && tr_accept |=> channel_in_queue_flags[$past(tr_channel)] && !tr_request)
      else $error("accepted channel not flagged in queue");

   a_no_offer_queued: assert property (
      $rose(tr_request) |-> !channel_in_queue_flags[tr_channel] && event_latch[tr_channel])
      else $error("offered a channel already in queue");

   a_null_holds_flag: assert property (
      dequeue && dequeue_null && channel_in_queue_flags[dequeue_channel] && sw_clear == '0
      |=> channel_in_queue_flags[$past(dequeue_channel)])
      else $error("null request released the in-queue flag");

   a_secondary_clear: assert property (
      s_write_to(`OFS_IN_QUEUE_CLEAR) ##0 !tr_request
      |=> (channel_in_queue_flags & $past(wbits)) == '0 && (event_latch & $past(wbits & ~new_event)) == '0)
      else $error("in-queue clear did not clear both words");

   a_reserved_zero: assert property (
      pready && !pwrite && addr <= `OFS_MISSED |-> prdata[31:8] == 24'h00_0000)
      else $error("reserved bits read nonzero");

   a_bus_one_wait: assert property (
      setup_phase ##1 psel && penable |-> pready)
      else $error("access phase not answered at once");

endmodule : qdma_channel_event_logic

// ==== verilog/qdma_event_regs.svh ====
`ifndef QDMA_EVENT_REGS_SVH
`define QDMA_EVENT_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_EVENT_LATCH 12'h000
`define OFS_EVENT_ENABLE 12'h004
`define OFS_ENABLE_CLEAR 12'h008
`define OFS_ENABLE_SET 12'h00C
`define OFS_IN_QUEUE 12'h010
`define OFS_IN_QUEUE_CLEAR 12'h014
`define OFS_MISSED 12'h018
`define OFS_MISSED_CLEAR 12'h01C
`define OFS_ARB_CTRL 12'h020
`define OFS_IRQ_STATUS 12'h024
`define OFS_IRQ_MASK 12'h028
`define OFS_MAPPING_BASE 12'h040
`define OFS_MAPPING_LAST 12'h05C

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MAP_WORD_LSB 2
`define MAP_WORD_W 3
`define MAP_ENTRY_LSB 5
`define ARB_QUICK_FIRST_BIT 0
`define IRQ_NULL_LSB 8
`define CHANNEL_RESET 8'h00
`define IRQ_RESET 16'h0000
`define ARB_RESET 1'b1

`endif

// ==== verilog/qdma_event_pkg.sv ====
package qdma_event_pkg;

   // ----------------------------------------------------------------
   // submission sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SUBMIT_IDLE = 2'b01,
      SUBMIT_OFFER = 2'b10
   } submit_state_t;

   typedef logic [31:0] apb_word_t;

endpackage : qdma_event_pkg

// ==== verilog/channel_picker.sv ====
module channel_picker #(
   parameter int CHANNELS = 8
) (
   input wire logic [CHANNELS-1:0] candidates,
   output logic found,
   output logic [2:0] index
);

   // ----------------------------------------------------------------
   // lowest channel number wins
   // ----------------------------------------------------------------
   function automatic logic [2:0] lowest_set(input logic [CHANNELS-1:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : lowest_set

   // fixed priority keeps the arbiter small; starvation is bounded by the in-queue hold
   always_comb begin
      found = |candidates;
      index = lowest_set(candidates);
   end

endmodule : channel_picker

// ==== tb/queue_partner.sv ====
// ----------------------------------------------------------------
// queue logic model: takes offered requests, reports queue leaves
// ----------------------------------------------------------------
module queue_partner (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic tr_request,
   input wire logic [2:0] tr_channel,
   input wire logic go,
   input wire logic [1:0] delay,
   input wire logic drain,
   input wire logic null_mode,
   output logic tr_accept,
   output logic dequeue,
   output logic [2:0] dequeue_channel,
   output logic dequeue_null
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] held [$];
   logic [1:0] wait_cnt;
   logic [2:0] gap;
   // accept after a chosen wait; the strobe drops once taken or withdrawn
   always @(posedge sys_clk) begin
      if (reset || !tr_request || tr_accept) begin
         tr_accept <= 1'b0;
         wait_cnt <= 2'h0;
      end else if (go && wait_cnt >= delay) begin
         tr_accept <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
   // one queue leave every eight cycles; idle channel lines toggle so stale values are not trusted
   always @(posedge sys_clk) begin
      dequeue <= 1'b0;
      dequeue_channel <= ~dequeue_channel;
      gap <= gap + 3'h1;
      if (reset) begin
         held.delete();
         dequeue_channel <= 3'h0;
         gap <= 3'h0;
      end else begin
         if (tr_request && tr_accept) held.push_back(tr_channel);
         if (drain && held.size() > 0 && gap == 3'h7) begin
            dequeue <= 1'b1;
            dequeue_channel <= held.pop_front();
         end
      end
   end
   assign dequeue_null = null_mode & dequeue;
endmodule : queue_partner

// ==== tb/testbench.sv ====
`include "qdma_event_regs.svh"
module testbench;
   import qdma_event_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic ram_write, link_update, normal_pending, tr_request, tr_accept, dequeue, dequeue_null;
   logic [6:0] ram_write_entry, link_entry;
   logic [2:0] ram_write_word, tr_channel, dequeue_channel;
   logic go, drain, null_mode;
   logic [1:0] delay;
   logic [6:0] ent [8];
   logic [32:0] exp_rd [$];
   logic [2:0] exp_gr [$];
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   qdma_channel_event_logic dut_u (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ram_write(ram_write), .ram_write_entry(ram_write_entry), .ram_write_word(ram_write_word),
      .link_update(link_update), .link_entry(link_entry), .normal_pending(normal_pending),
      .tr_request(tr_request), .tr_channel(tr_channel), .tr_accept(tr_accept), .dequeue(dequeue),
      .dequeue_channel(dequeue_channel), .dequeue_null(dequeue_null), .irq(irq));
   queue_partner partner_u (.sys_clk(sys_clk), .reset(reset), .tr_request(tr_request), .tr_channel(tr_channel),
      .go(go), .delay(delay), .drain(drain), .null_mode(null_mode), .tr_accept(tr_accept), .dequeue(dequeue),
      .dequeue_channel(dequeue_channel), .dequeue_null(dequeue_null));
   // ----------------------------------------------------------------
   // compare and closing tasks
   // ----------------------------------------------------------------
   task check_word(input logic [32:0] got, input logic [32:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word
   task check_grant(input logic [2:0] got);
      logic [2:0] exp;
      exp = (exp_gr.size() > 0) ? exp_gr.pop_front() : ~got;
      check_word({30'h0, got}, {30'h0, exp});
   endtask : check_grant
   task finish_test();
      miscompares += exp_gr.size() + exp_rd.size();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // ----------------------------------------------------------------
   // bus and event drivers
   // ----------------------------------------------------------------
   // the request is held until pready is seen at an edge, never released early
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) exp_rd.push_back(e);
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask : rd
   task fire(input logic lnk, input int ch);
      @(posedge sys_clk);
      ram_write <= !lnk;
      link_update <= lnk;
      ram_write_entry <= ent[ch];
      link_entry <= ent[ch];
      ram_write_word <= 3'h7;
      @(posedge sys_clk);
      ram_write <= 1'b0;
      link_update <= 1'b0;
   endtask : fire
   task idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle
   task check_irq(input logic e);
      idle(2);
      check_word({32'h0, irq}, {32'h0, e});
   endtask : check_irq
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   // monitor: oldest note is taken off whenever a result shows at the ports
   always @(posedge sys_clk) begin
      cycles++;
      if (psel && penable && pready === 1'b1 && !pwrite) check_word({pslverr, prdata}, exp_rd.pop_front());
      if (tr_request === 1'b1 && tr_accept) check_grant(tr_channel);
      if (cycles == 5000) begin
         miscompares++;
         finish_test();
      end
   end
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      {ram_write, link_update, ram_write_entry, link_entry, ram_write_word, normal_pending} = '0;
      {go, drain, null_mode, delay} = '0;
      void'($urandom(32'h67928cef));
      idle(3);
      reset <= 1'b0;
      for (int a = 0; a < 24; a += 4) rd(12'(a), 32'h0);
      apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0});
      rd(`OFS_ARB_CTRL, 32'h1);
      for (int c = 0; c < 8; c++) begin
         ent[c] = {3'(c), 4'($urandom)};
         wr(12'(`OFS_MAPPING_BASE + 4 * c), {20'h0, ent[c], 5'h1C});
      end
      fire(1'b0, 3);
      rd(`OFS_EVENT_LATCH, 32'h0);
      wr(`OFS_EVENT_ENABLE, 32'hFFFFFFFF);
      rd(`OFS_EVENT_ENABLE, 32'h0);
      wr(`OFS_ENABLE_SET, 32'hFFFFFFFF);
      rd(`OFS_EVENT_ENABLE, 32'hFF);
      wr(`OFS_ENABLE_CLEAR, 32'h0F);
      rd(`OFS_EVENT_ENABLE, 32'hF0);
      rd(`OFS_ENABLE_CLEAR, 32'h0);
      fire(1'b0, 2);
      fire(1'b0, 5);
      fire(1'b1, 6);
      rd(`OFS_EVENT_LATCH, 32'h60);
      fire(1'b0, 5);
      rd(`OFS_MISSED, 32'h20);
      rd(`OFS_IRQ_STATUS, 32'h20);
      wr(`OFS_IRQ_MASK, 32'h20);
      check_irq(1'b1);
      wr(`OFS_IRQ_STATUS, 32'h20);
      wr(`OFS_MISSED_CLEAR, 32'h20);
      check_irq(1'b0);
      exp_gr = '{3'h5, 3'h6};
      delay <= 2'($urandom);
      go <= 1'b1;
      idle(20);
      rd(`OFS_EVENT_LATCH, 32'h0);
      rd(`OFS_IN_QUEUE, 32'h60);
      fire(1'b0, 5);
      idle(10);
      rd(`OFS_EVENT_LATCH, 32'h20);
      exp_gr.push_back(3'h5);
      drain <= 1'b1;
      idle(60);
      rd(`OFS_IN_QUEUE, 32'h0);
      null_mode <= 1'b1;
      delay <= 2'($urandom);
      exp_gr.push_back(3'h4);
      fire(1'b0, 4);
      idle(40);
      rd(`OFS_IN_QUEUE, 32'h10);
      rd(`OFS_IRQ_STATUS, 32'h1000);
      drain <= 1'b0;
      exp_gr.push_back(3'h7);
      fire(1'b0, 7);
      idle(10);
      fire(1'b0, 7);
      rd(`OFS_EVENT_LATCH, 32'h80);
      rd(`OFS_IN_QUEUE, 32'h90);
      wr(`OFS_IN_QUEUE_CLEAR, 32'h90);
      rd(`OFS_IN_QUEUE, 32'h0);
      rd(`OFS_EVENT_LATCH, 32'h0);
      // normal events first: a quick event must wait while one is pending
      wr(`OFS_ARB_CTRL, 32'h0);
      normal_pending <= 1'b1;
      fire(1'b0, 5);
      idle(10);
      rd(`OFS_EVENT_LATCH, 32'h20);
      exp_gr.push_back(3'h5);
      normal_pending <= 1'b0;
      idle(10);
      rd(`OFS_IN_QUEUE, 32'h20);
      // event lands in the very cycle of the in-queue clear: the set must survive
      exp_gr.push_back(3'h5);
      fork
         wr(`OFS_IN_QUEUE_CLEAR, 32'h20);
         begin
            @(posedge sys_clk);
            fire(1'b0, 5);
         end
      join
      idle(10);
      rd(`OFS_IN_QUEUE, 32'h20);
      idle(10);
      finish_test();
   end
endmodule : testbench
